// *** shared/hbp_pkg.sv ***
// Package for the fixed-wait host bus port: constants and carrier types
package hbp_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 16;
    // Bus clock periods (T) from access start to read data valid, per ratio 1..4
    // Half periods are rounded up to the next whole bus clock edge
    localparam logic [4:0] RD_LAT_DIV1 = 5'h06;
    localparam logic [4:0] RD_LAT_DIV2 = 5'h09;
    localparam logic [4:0] RD_LAT_DIV3 = 5'h0B;
    localparam logic [4:0] RD_LAT_DIV4 = 5'h0F;
    // Longest chip select time in bus clock periods per ratio
    localparam logic [4:0] CS_MAX_DIV1 = 5'h08;
    localparam logic [4:0] CS_MAX_DIV2 = 5'h0B;
    localparam logic [4:0] CS_MAX_DIV3 = 5'h0D;
    localparam logic [4:0] CS_MAX_DIV4 = 5'h11;
    // Write data is taken at the third rising edge; first edge is count 1
    localparam logic [4:0] WR_LATCH_EDGE = 5'h03;
    localparam logic [1:0] DIV_SEL_1 = 2'h0;
    localparam logic [1:0] DIV_SEL_2 = 2'h1;
    localparam logic [1:0] DIV_SEL_3 = 2'h2;
    localparam logic [1:0] DIV_SEL_4 = 2'h3;
    localparam logic [4:0] CNT_ONE = 5'h01;

    typedef enum logic [1:0] {
        HBP_IDLE = 2'b00,
        HBP_WRITE = 2'b01,
        HBP_READ = 2'b11,
        HBP_DONE = 2'b10
    } hbp_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic upperEn;
        logic lowerEn;
    } hbp_wr_t;
endpackage

// *** verilog/hbp_port.sv ***
// Slave port for a synchronous 16-bit host bus timed by fixed wait states
`timescale 1ns/1ns
// Function
// - Capture address at first qualified bus edge
// - Access ends within 8 or 11 periods
// - Access ends within 13 or 17 periods
// - Latch write word at third edge
// - Drive data only during reads after enable
// - Read data valid after ratio-dependent delay
// - Release data bus on edge after read
module hbp_port
(
    // Clock (host bus clock) and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Host bus pins
    input wire logic chipSelectBarN,
    input wire logic upperByteWriteStrobeN,
    input wire logic lowerByteWriteStrobeN,
    input wire logic outputEnableN,
    input wire logic [hbp_pkg::ADDR_W-1:0] addrIn,
    input wire logic [hbp_pkg::DATA_W-1:0] dataIn,
    output logic [hbp_pkg::DATA_W-1:0] dataOut,
    output logic dataOeN,
    // Static configuration: memory clock divide select, 0..3 for ratio 1..4
    input wire logic [1:0] memDivSel,
    // Internal memory side
    output hbp_pkg::hbp_wr_t wrReq,
    output logic wrValid,
    output logic [hbp_pkg::ADDR_W-1:0] rdAddr,
    output logic rdValid,
    input wire logic [hbp_pkg::DATA_W-1:0] rdData,
    output logic accessOverrun
);
    hbp_pkg::hbp_state_t state_ff, nxt_state;
    logic [4:0] cnt_ff, nxt_cnt;
    logic [hbp_pkg::ADDR_W-1:0] addr_ff, nxt_addr;
    hbp_pkg::hbp_wr_t wrReq_ff, nxt_wrReq;
    logic wrValid_ff, nxt_wrValid;
    logic rdValid_ff, nxt_rdValid;
    logic [hbp_pkg::DATA_W-1:0] dataOut_ff, nxt_dataOut;
    logic dataOeN_ff, nxt_dataOeN;
    logic overrun_ff, nxt_overrun;
    logic [4:0] rdLat, csMax;
    logic csAct, wrAct, rdAct;

    assign csAct = !chipSelectBarN;
    assign wrAct = !upperByteWriteStrobeN || !lowerByteWriteStrobeN;
    assign rdAct = !outputEnableN;

    // Timing follows the static divide select
    always_comb
    begin
        unique case (memDivSel)
            hbp_pkg::DIV_SEL_1:
            begin
                rdLat = hbp_pkg::RD_LAT_DIV1;
                csMax = hbp_pkg::CS_MAX_DIV1;
            end
            hbp_pkg::DIV_SEL_2:
            begin
                rdLat = hbp_pkg::RD_LAT_DIV2;
                csMax = hbp_pkg::CS_MAX_DIV2;
            end
            hbp_pkg::DIV_SEL_3:
            begin
                rdLat = hbp_pkg::RD_LAT_DIV3;
                csMax = hbp_pkg::CS_MAX_DIV3;
            end
            hbp_pkg::DIV_SEL_4:
            begin
                rdLat = hbp_pkg::RD_LAT_DIV4;
                csMax = hbp_pkg::CS_MAX_DIV4;
            end
        endcase
    end

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_addr = addr_ff;
        nxt_wrReq = wrReq_ff;
        nxt_wrValid = 1'b0;
        nxt_rdValid = 1'b0;
        nxt_dataOut = dataOut_ff;
        nxt_dataOeN = 1'b1;
        nxt_overrun = overrun_ff;
        unique case (state_ff)
            hbp_pkg::HBP_IDLE:
            begin
                if (csAct && (wrAct || rdAct))
                begin
                    nxt_addr = addrIn;
                    nxt_cnt = hbp_pkg::CNT_ONE;
                    nxt_state = wrAct ? hbp_pkg::HBP_WRITE : hbp_pkg::HBP_READ;
                    nxt_overrun = 1'b0;
                end
            end
            hbp_pkg::HBP_WRITE:
            begin
                if (!csAct)
                    nxt_state = hbp_pkg::HBP_IDLE;
                else
                begin
                    nxt_cnt = cnt_ff + hbp_pkg::CNT_ONE;
                    // Strobes sampled here too: host keeps them until chip select
                    if (nxt_cnt == hbp_pkg::WR_LATCH_EDGE)
                    begin
                        nxt_wrReq.addr = addr_ff;
                        nxt_wrReq.data = dataIn;
                        nxt_wrReq.upperEn = !upperByteWriteStrobeN;
                        nxt_wrReq.lowerEn = !lowerByteWriteStrobeN;
                        nxt_wrValid = 1'b1;
                        nxt_state = hbp_pkg::HBP_DONE;
                    end
                end
            end
            hbp_pkg::HBP_READ:
            begin
                // Output enable held to chip select end by the host
                if (!csAct)
                    nxt_state = hbp_pkg::HBP_IDLE;
                else
                begin
                    nxt_dataOeN = 1'b0;
                    nxt_cnt = cnt_ff + hbp_pkg::CNT_ONE;
                    if (nxt_cnt == rdLat - hbp_pkg::CNT_ONE)
                        nxt_rdValid = 1'b1;
                    if (nxt_cnt == rdLat)
                        nxt_dataOut = rdData;
                    if (cnt_ff == csMax)
                        nxt_overrun = 1'b1;
                end
            end
            hbp_pkg::HBP_DONE:
            begin
                if (!csAct)
                    nxt_state = hbp_pkg::HBP_IDLE;
                else if (cnt_ff != csMax)
                    nxt_cnt = cnt_ff + hbp_pkg::CNT_ONE;
                else
                    nxt_overrun = 1'b1;
            end
        endcase
    end

    // Host must not pick ratio 3 or 4 unless it stretches to 10/12 waits
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            state_ff <= hbp_pkg::HBP_IDLE;
            cnt_ff <= '0;
            addr_ff <= '0;
            wrReq_ff <= '0;
            wrValid_ff <= 1'b0;
            rdValid_ff <= 1'b0;
            dataOut_ff <= '0;
            dataOeN_ff <= 1'b1;
            overrun_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            addr_ff <= nxt_addr;
            wrReq_ff <= nxt_wrReq;
            wrValid_ff <= nxt_wrValid;
            rdValid_ff <= nxt_rdValid;
            dataOut_ff <= nxt_dataOut;
            dataOeN_ff <= nxt_dataOeN;
            overrun_ff <= nxt_overrun;
        end
    end

    assign dataOut = dataOut_ff;
    assign dataOeN = dataOeN_ff;
    assign wrReq = wrReq_ff;
    assign wrValid = wrValid_ff;
    assign rdAddr = addr_ff;
    assign rdValid = rdValid_ff;
    assign accessOverrun = overrun_ff;

    sequence s_wrStart;
        state_ff == hbp_pkg::HBP_IDLE && csAct && wrAct;
    endsequence

    sequence s_wrHold;
        csAct [*3];
    endsequence

    a_addr_capture: assert property (@(posedge clk_sys) disable iff (!rstn)
        state_ff == hbp_pkg::HBP_IDLE && csAct && (wrAct || rdAct)
        |=> addr_ff == $past(addrIn))
        else $error("address not captured at first edge");

    a_write_latch: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_wrStart ##0 s_wrHold |=> wrValid_ff && wrReq_ff.data == $past(dataIn))
        else $error("write word not latched at third edge");

    a_write_single: assert property (@(posedge clk_sys) disable iff (!rstn)
        wrValid_ff |=> !wrValid_ff)
        else $error("write pulse longer than one cycle");

    a_bus_idle_float: assert property (@(posedge clk_sys) disable iff (!rstn)
        state_ff != hbp_pkg::HBP_READ |=> dataOeN_ff)
        else $error("data bus driven outside a read");

    a_read_release: assert property (@(posedge clk_sys) disable iff (!rstn)
        !csAct |=> dataOeN_ff)
        else $error("data bus not released after read");

    a_read_drive: assert property (@(posedge clk_sys) disable iff (!rstn)
        state_ff == hbp_pkg::HBP_READ && csAct |=> !dataOeN_ff)
        else $error("data bus not driven during read");

    a_read_valid: assert property (@(posedge clk_sys) disable iff (!rstn)
        state_ff == hbp_pkg::HBP_READ && csAct && cnt_ff == rdLat - hbp_pkg::CNT_ONE
        |=> dataOut_ff == $past(rdData))
        else $error("read data late");

    a_div_latency: assert property (@(posedge clk_sys) disable iff (!rstn)
        memDivSel == hbp_pkg::DIV_SEL_1 |-> rdLat == hbp_pkg::RD_LAT_DIV1
        && csMax == hbp_pkg::CS_MAX_DIV1)
        else $error("ratio 1 timing wrong");

    a_overrun_flag: assert property (@(posedge clk_sys) disable iff (!rstn)
        state_ff == hbp_pkg::HBP_DONE && csAct && cnt_ff == csMax |=> accessOverrun)
        else $error("overlong access not flagged");
endmodule

// *** test/hbp_host_model.sv ***
// Host bus controller model: fixed wait-state accesses, no acknowledge
`timescale 1ns/1ns
module hbp_host_model
(
    // Clock
    input wire logic clk_sys,
    // Host bus pins
    output logic chipSelectBarN,
    output logic upperByteWriteStrobeN,
    output logic lowerByteWriteStrobeN,
    output logic outputEnableN,
    output logic [hbp_pkg::ADDR_W-1:0] addrIn,
    output logic [hbp_pkg::DATA_W-1:0] dataIn,
    input wire logic [hbp_pkg::DATA_W-1:0] dataOut
);
    initial
    begin
        {chipSelectBarN, upperByteWriteStrobeN, lowerByteWriteStrobeN, outputEnableN} = 4'hF;
        addrIn = 16'h0000;
        dataIn = 16'hFFFF;
    end

    // Wait states 4, 6, 10, 12 give these chip select lengths
    function automatic int csLen(input logic [1:0] sel);
        case (sel)
            2'h0: return 7;
            2'h1: return 10;
            2'h2: return 12;
            default: return 16;
        endcase
    endfunction

    // This host can stretch to the long lengths, so ratios 3 and 4 are allowed
    task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d,
        input logic [1:0] be, input logic [1:0] sel, input int extra, output logic [15:0] rd);
        @(posedge clk_sys);
        #1;
        chipSelectBarN = 1'b0;
        addrIn = a;
        // Word shows up only after the second edge, so an early latch sees garbage
        dataIn = ~d;
        if (wr)
        begin
            {upperByteWriteStrobeN, lowerByteWriteStrobeN} = ~be;
        end
        else
        begin
            outputEnableN = 1'b0;
        end
        repeat (2) @(posedge clk_sys);
        #1;
        dataIn = d;
        repeat (csLen(sel) + extra - 2) @(posedge clk_sys);
        rd = dataOut;
        #1;
        // Strobes and enable leave together with chip select
        {chipSelectBarN, upperByteWriteStrobeN, lowerByteWriteStrobeN, outputEnableN} = 4'hF;
        // Released lines show the inverse so stale values never match
        addrIn = ~a;
        dataIn = ~d;
    endtask
endmodule

// *** test/test_host_bus_fixed_wait_port.sv ***
// Testbench for the fixed-wait host bus port
`timescale 1ns/1ns
module test_host_bus_fixed_wait_port;
    logic clk_sys;
    logic rstn;
    logic [1:0] divSel;
    logic csN, ubN, lbN, oeN, dataOeN, wrValid, rdValid, accessOverrun;
    logic prevOeN;
    logic [15:0] addrIn, dataIn, dataOut, rdAddr, rdData, rd;
    hbp_pkg::hbp_wr_t wrReq, lastWr;
    int n_errors, checks, nWr, nRd, nBadDrive;

    hbp_host_model u_host (.clk_sys(clk_sys), .chipSelectBarN(csN),
        .upperByteWriteStrobeN(ubN), .lowerByteWriteStrobeN(lbN), .outputEnableN(oeN),
        .addrIn(addrIn), .dataIn(dataIn), .dataOut(dataOut));
    hbp_port u_dut (.clk_sys(clk_sys), .rstn(rstn), .chipSelectBarN(csN),
        .upperByteWriteStrobeN(ubN), .lowerByteWriteStrobeN(lbN), .outputEnableN(oeN),
        .addrIn(addrIn), .dataIn(dataIn), .dataOut(dataOut), .dataOeN(dataOeN),
        .memDivSel(divSel), .wrReq(wrReq), .wrValid(wrValid), .rdAddr(rdAddr),
        .rdValid(rdValid), .rdData(rdData), .accessOverrun(accessOverrun));

    // Memory stand-in answers with a pattern of the address
    assign rdData = rdAddr ^ 16'h5A5A;

    always @(posedge clk_sys)
    begin
        if (wrValid === 1'b1)
        begin
            lastWr = wrReq;
            nWr++;
        end
        if (rdValid === 1'b1) nRd++;
        // Flops are unknown until the first reset edge, so only judge once out of reset
        if (rstn === 1'b1 && dataOeN !== 1'b1 && prevOeN === 1'b1) nBadDrive++;
        prevOeN = oeN;
    end

    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic t_writes();
        divSel = 2'h0;
        for (int i = 0; i < 3; i++)
        begin
            u_host.access(1'b1, 16'h1230 + i[15:0], 16'hBEE0 + i[15:0], 2'(i + 1), divSel, 0, rd);
            cmp("write count", 16'(i + 1), 16'(nWr));
            cmp("write addr", 16'h1230 + i[15:0], lastWr.addr);
            cmp("write data", 16'hBEE0 + i[15:0], lastWr.data);
            cmp("byte enables", 16'(i + 1), {14'h0000, lastWr.upperEn, lastWr.lowerEn});
        end
    endtask

    task automatic t_reads();
        for (int s = 0; s < 4; s++)
        begin
            divSel = s[1:0];
            u_host.access(1'b0, 16'hC000 + s[15:0], 16'h0000, 2'h0, divSel, 0, rd);
            cmp("read data", (16'hC000 + s[15:0]) ^ 16'h5A5A, rd);
            cmp("read addr", 16'hC000 + s[15:0], rdAddr);
            cmp("read count", 16'(s + 1), 16'(nRd));
            cmp("no overrun", 16'h0000, {15'h0000, accessOverrun});
            @(posedge clk_sys);
            #1;
            cmp("bus released", 16'h0001, {15'h0000, dataOeN});
        end
    endtask

    task automatic t_overrun();
        divSel = 2'h0;
        u_host.access(1'b1, 16'h0042, 16'h7E7E, 2'h3, divSel, 3, rd);
        cmp("overrun set", 16'h0001, {15'h0000, accessOverrun});
        u_host.access(1'b0, 16'h0043, 16'h0000, 2'h0, divSel, 0, rd);
        cmp("overrun clear", 16'h0000, {15'h0000, accessOverrun});
        cmp("read after overrun", 16'h0043 ^ 16'h5A5A, rd);
    endtask

    task automatic close_out();
        if (n_errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    initial
    begin
        #2000000;
        n_errors++;
        close_out();
    end

    initial
    begin
        rstn = 1'b0;
        divSel = 2'h0;
        prevOeN = 1'b1;
        repeat (5) @(posedge clk_sys);
        #1;
        rstn = 1'b1;
        t_writes();
        t_reads();
        t_overrun();
        cmp("undriven outside reads", 16'h0000, 16'(nBadDrive));
        close_out();
    end
endmodule
